// file: rtl/sph_ppi_top.sv
// port a/b/c strobed handshake and control-pin logic
`default_nettype none
module sph_ppi_top import sph_pkg::*; (
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    input  wire logic          ce_i,
    input  wire sph_cfg_s      cfg_i,
    input  wire sph_host_s     host_i,
    input  wire sph_bsr_s      bsr_i,
    output logic [DW-1:0]      host_data_o,
    output logic               host_data_oe_o,
    input  wire logic [DW-1:0] pa_i,
    output logic [DW-1:0]      pa_o,
    output logic               pa_oe_o,
    input  wire logic [DW-1:0] pb_i,
    output logic [DW-1:0]      pb_o,
    output logic               pb_oe_o,
    input  wire logic [7:0]    pc_i,
    output logic [7:0]         pc_o,
    output logic [7:0]         pc_oe_o
);
    typedef struct packed {
        logic [DW-1:0] pa_out;
        logic [DW-1:0] pb_out;
        logic [7:0]    pc_out;
        logic          gate_a_in;
        logic          gate_a_out;
        logic          gate_b;
        logic [DW-1:0] rd_data;
    } sph_top_s;

    sph_top_s      st_reg;
    sph_top_s      st_next;

    // mode decode
    logic          a_m0;
    logic          a_m2;
    logic          a_strobe;
    logic          a_in_en;
    logic          a_out_en;
    logic          b_strobe;
    logic          b_in_en;
    logic          b_out_en;

    // port c allocation
    logic [7:0]    ctl_mask;
    logic [7:0]    hs_oe;
    logic [7:0]    hs_val;
    logic [7:0]    left_in;
    logic [7:0]    left_out;

    // qualified host strobes
    logic          rd_a_n;
    logic          wr_a_n;
    logic          rd_b_n;
    logic          wr_b_n;

    // channel and buffer links
    logic          obf_a_n;
    logic          obf_b_n;
    logic          irq_a;
    logic          irq_b;
    logic          push_a;
    logic          push_b;
    logic          pop_a;
    logic          pop_b;
    logic          room_a;
    logic          room_b;
    logic          ibf_a;
    logic          ibf_b;
    logic [DW-1:0] in_a;
    logic [DW-1:0] in_b;

    always_comb begin
        a_m0 = 1'b1;
        a_m2 = 1'b0;
        case (cfg_i.mode_a)
            SPH_M0: begin
                a_m0 = 1'b1;
            end
            SPH_M1: begin
                a_m0 = 1'b0;
            end
            SPH_M2: begin
                a_m0 = 1'b0;
                a_m2 = 1'b1;
            end
            default: begin
                a_m0 = 1'b1;
            end
        endcase
        // bidir mode is not offered to group b
        case (cfg_i.mode_b)
            SPH_M1: begin
                b_strobe = 1'b1;
            end
            default: begin
                b_strobe = 1'b0;
            end
        endcase
    end

    // each group decodes its own mode independently
    assign a_strobe = !a_m0;
    assign a_in_en  = a_m2 || (a_strobe && cfg_i.a_in);
    assign a_out_en = a_m2 || (a_strobe && !cfg_i.a_in);
    assign b_in_en  = b_strobe && cfg_i.b_in;
    assign b_out_en = b_strobe && !cfg_i.b_in;

    // handshake pins: irq b, flag b, strobe/ack b, irq a, a side
    assign ctl_mask = {{2{a_out_en}}, {2{a_in_en}}, a_strobe,
                       {3{b_strobe}}};
    assign hs_oe    = {a_out_en, 1'b0, a_in_en, 1'b0, a_strobe,
                       1'b0, b_strobe, b_strobe};
    assign hs_val   = {obf_a_n, 1'b0, ibf_a, 1'b0, irq_a,
                       1'b0, (b_in_en ? ibf_b : obf_b_n), irq_b};

    // leftover direction from control word bits 3 and 0
    assign left_in  = ~ctl_mask & {{4{cfg_i.pc_hi_in}},
                                   {4{cfg_i.pc_lo_in}}};
    assign left_out = ~ctl_mask & ~left_in;

    assign pc_oe_o  = (ctl_mask & hs_oe) | left_out;
    assign pc_o     = (ctl_mask & hs_val) | (~ctl_mask & st_reg.pc_out);

    assign rd_a_n   = host_i.rd_n || (host_i.addr != ADDR_PA);
    assign wr_a_n   = host_i.wr_n || (host_i.addr != ADDR_PA);
    assign rd_b_n   = host_i.rd_n || (host_i.addr != ADDR_PB);
    assign wr_b_n   = host_i.wr_n || (host_i.addr != ADDR_PB);

    sph_hs_chan u_chan_a (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .ce_i       (ce_i),
        .in_en_i    (a_in_en),
        .out_en_i   (a_out_en),
        .stb_n_i    (pc_i[PC_STB_A]),
        .ack_n_i    (pc_i[PC_ACK_A]),
        .rd_n_i     (rd_a_n),
        .wr_n_i     (wr_a_n),
        .in_full_i  (ibf_a),
        .in_room_i  (room_a),
        .in_gate_i  (st_reg.gate_a_in),
        .out_gate_i (st_reg.gate_a_out),
        .obf_n_o    (obf_a_n),
        .irq_o      (irq_a),
        .push_o     (push_a),
        .pop_o      (pop_a)
    );

    sph_hs_chan u_chan_b (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .ce_i       (ce_i),
        .in_en_i    (b_in_en),
        .out_en_i   (b_out_en),
        .stb_n_i    (pc_i[PC_HS_B]),
        .ack_n_i    (pc_i[PC_HS_B]),
        .rd_n_i     (rd_b_n),
        .wr_n_i     (wr_b_n),
        .in_full_i  (ibf_b),
        .in_room_i  (room_b),
        .in_gate_i  (st_reg.gate_b),
        .out_gate_i (st_reg.gate_b),
        .obf_n_o    (obf_b_n),
        .irq_o      (irq_b),
        .push_o     (push_b),
        .pop_o      (pop_b)
    );

    // input latch: strobe fall pushes, host read rise pops
    sph_buf2 #(.W(DW)) u_buf_a (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .ce_i        (ce_i),
        .in_valid_i  (push_a),
        .in_ready_o  (room_a),
        .in_data_i   (pa_i),
        .out_valid_o (ibf_a),
        .out_ready_i (pop_a),
        .out_data_o  (in_a)
    );

    sph_buf2 #(.W(DW)) u_buf_b (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .ce_i        (ce_i),
        .in_valid_i  (push_b),
        .in_ready_o  (room_b),
        .in_data_i   (pb_i),
        .out_valid_o (ibf_b),
        .out_ready_i (pop_b),
        .out_data_o  (in_b)
    );

    always_comb begin
        st_next = st_reg;
        if (!host_i.wr_n) begin
            case (host_i.addr)
                ADDR_PA: begin
                    st_next.pa_out = host_i.data;
                end
                ADDR_PB: begin
                    st_next.pb_out = host_i.data;
                end
                ADDR_PC: begin
                    for (int i = 0; i < 3; i++) begin
                        if (left_out[i]) begin
                            st_next.pc_out[i] = host_i.data[i];
                        end
                    end
                end
                default: begin
                    st_next.pc_out = st_reg.pc_out;
                end
            endcase
        end
        if (bsr_i.we) begin
            if (!ctl_mask[bsr_i.bit_sel]) begin
                st_next.pc_out[bsr_i.bit_sel] = bsr_i.val;
            end else if (bsr_i.bit_sel == PC_STB_A) begin
                st_next.gate_a_in = bsr_i.val;
            end else if (bsr_i.bit_sel == PC_ACK_A) begin
                st_next.gate_a_out = bsr_i.val;
            end else if (bsr_i.bit_sel == PC_HS_B) begin
                st_next.gate_b = bsr_i.val;
            end
        end
        if (!host_i.rd_n) begin
            case (host_i.addr)
                ADDR_PA: begin
                    st_next.rd_data = a_in_en ? in_a
                                    : (cfg_i.a_in ? pa_i : st_reg.pa_out);
                end
                ADDR_PB: begin
                    st_next.rd_data = b_in_en ? in_b
                                    : (cfg_i.b_in ? pb_i : st_reg.pb_out);
                end
                ADDR_PC: begin
                    st_next.rd_data = (left_in & pc_i)
                                    | (~left_in & pc_o);
                end
                default: begin
                    st_next.rd_data = RST_LATCH;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg <= '{RST_LATCH, RST_LATCH, RST_LATCH,
                        RST_FLAG, RST_FLAG, RST_FLAG, RST_LATCH};
        end else if (ce_i) begin
            st_reg <= st_next;
        end
    end

    // bidir: latch floats until ack pulls low
    assign pa_o    = st_reg.pa_out;
    assign pa_oe_o = a_m2 ? !pc_i[PC_ACK_A]
                          : !cfg_i.a_in;
    assign pb_o    = st_reg.pb_out;
    assign pb_oe_o = !cfg_i.b_in;

    // host bus driven only while a read is under way
    assign host_data_o    = st_reg.rd_data;
    assign host_data_oe_o = !host_i.rd_n
                         && (host_i.addr != 2'h3);

    AST_PC3_IRQ_A: assert property (@(posedge clk_i) disable iff (rst_i)
        a_strobe |-> pc_oe_o[PC_IRQ_A] && (pc_o[PC_IRQ_A] == irq_a))
        else $error("bit 3 does not carry group a irq");
    AST_PA_HIZ_M2: assert property (@(posedge clk_i) disable iff (rst_i)
        a_m2 && pc_i[PC_ACK_A] |-> !pa_oe_o)
        else $error("port a driven in bidir mode without ack");
    AST_PA_DRV_M2: assert property (@(posedge clk_i) disable iff (rst_i)
        a_m2 && !pc_i[PC_ACK_A] |-> pa_oe_o && (pa_o == st_reg.pa_out))
        else $error("port a not driven from latch during ack");
    AST_HOST_HIZ: assert property (@(posedge clk_i) disable iff (rst_i)
        host_i.rd_n |-> !host_data_oe_o)
        else $error("host bus driven outside a read");
    AST_IBF_SET: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && push_a |=> ibf_a && pc_o[PC_IBF_A])
        else $error("input-full not set after strobe fall");
    AST_GATE_OUT: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && bsr_i.we && a_out_en && (bsr_i.bit_sel == PC_ACK_A)
        |=> st_reg.gate_a_out == $past(bsr_i.val))
        else $error("output-side gate not updated by bit 6");
    AST_GATE_IN: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && bsr_i.we && a_in_en && (bsr_i.bit_sel == PC_STB_A)
        |=> st_reg.gate_a_in == $past(bsr_i.val))
        else $error("input-side gate not updated by bit 4");
    AST_UPPER_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && !host_i.wr_n && (host_i.addr == ADDR_PC) && !bsr_i.we
        |=> st_reg.pc_out[7:4] == $past(st_reg.pc_out[7:4]))
        else $error("upper leftover bits changed by port c write");
    AST_LOW_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && !host_i.wr_n && (host_i.addr == ADDR_PC) && !bsr_i.we
        && left_out[0] |=> st_reg.pc_out[0] == $past(host_i.data[0]))
        else $error("low leftover bit not written by port c write");
    AST_LEFT_READ: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && !host_i.rd_n && (host_i.addr == ADDR_PC) && left_in[2]
        |=> host_data_o[2] == $past(pc_i[2]))
        else $error("leftover input bit not read from pin");
    // leftover bits follow the control word direction bits
    AST_LEFT_LO_DIR: assert property (@(posedge clk_i) disable iff (rst_i)
        !ctl_mask[0] |-> pc_oe_o[0] == !cfg_i.pc_lo_in)
        else $error("low leftover bit direction wrong");
    AST_LEFT_HI_DIR: assert property (@(posedge clk_i) disable iff (rst_i)
        !ctl_mask[7] |-> pc_oe_o[7] == !cfg_i.pc_hi_in)
        else $error("upper leftover bit direction wrong");
endmodule : sph_ppi_top
`default_nettype wire

// file: rtl/sph_pkg.sv
// package: constants and types of the strobed port handshake block
`default_nettype none
package sph_pkg;
// Functional notes
// - strobed mode maps port c pins per group and direction
// - bit 3 carries the group a irq whenever group a is strobed
// - bits not used for handshake stay plain mode 0 bits
// - bidirectional strobed mode on port a, group a only
// - bidir mode: written latch not driven out before acknowledge
// - bidir output-full low on write rise, high on ack fall
// - ack low drives port a from latch, ack high floats it
// - load strobe captures pins; host bus driven only during read
// - input-full high on strobe fall, low on the read rise that takes the last buffered word
// - two gate flops, output side and input side, gate the irq
// - output-side gate set or cleared through bit 6 set/reset
// - input-side gate set or cleared through bit 4 set/reset
// - bidir mode: bits 3..7 irq, strobe, full, ack, out-full
// - groups a and b may run different modes together
// - leftover upper direction from word bit 3, lower from bit 0
// - leftover input bits return pin values on port c read
// - leftover upper output bits change only by set/reset
// - leftover output bits 2..0 writable by port c write
// - set/reset honoured on leftover port c bits 7 down to 0
// - gate set by bit-set, cleared by bit-reset; clear blocks irq
// - input irq rises on strobe rise if full, falls on read fall
// - output irq rises on ack rise if not full, falls on write fall
    localparam int          DW        = 8;
    localparam logic [1:0]  ADDR_PA   = 2'h0;
    localparam logic [1:0]  ADDR_PB   = 2'h1;
    localparam logic [1:0]  ADDR_PC   = 2'h2;
    localparam logic [2:0]  PC_IRQ_B  = 3'h0;
    localparam logic [2:0]  PC_FLG_B  = 3'h1;
    localparam logic [2:0]  PC_HS_B   = 3'h2;
    localparam logic [2:0]  PC_IRQ_A  = 3'h3;
    localparam logic [2:0]  PC_STB_A  = 3'h4;
    localparam logic [2:0]  PC_IBF_A  = 3'h5;
    localparam logic [2:0]  PC_ACK_A  = 3'h6;
    localparam logic [2:0]  PC_OBF_A  = 3'h7;
    localparam logic        RST_OBF_N = 1'h1;
    localparam logic        RST_FLAG  = 1'h0;
    localparam logic [7:0]  RST_LATCH = 8'h00;

    typedef enum logic [2:0] {
        SPH_M0 = 3'h1,
        SPH_M1 = 3'h2,
        SPH_M2 = 3'h4
    } sph_mode_e;

    typedef struct packed {
        sph_mode_e mode_a;
        sph_mode_e mode_b;
        logic      a_in;
        logic      b_in;
        logic      pc_hi_in;
        logic      pc_lo_in;
    } sph_cfg_s;

    typedef struct packed {
        logic          rd_n;
        logic          wr_n;
        logic [1:0]    addr;
        logic [DW-1:0] data;
    } sph_host_s;

    typedef struct packed {
        logic       we;
        logic [2:0] bit_sel;
        logic       val;
    } sph_bsr_s;

    typedef struct packed {
        logic stb_p;
        logic ack_p;
        logic rd_p;
        logic wr_p;
        logic obf_n;
        logic irq_in;
        logic irq_out;
    } sph_chan_s;

    localparam sph_chan_s CHAN_RST = '{1'h1, 1'h1, 1'h1, 1'h1,
                                       RST_OBF_N, RST_FLAG, RST_FLAG};
endpackage : sph_pkg
`default_nettype wire

// file: rtl/sph_buf2.sv
// two-entry buffer with valid/ready on both sides
`default_nettype none
module sph_buf2 import sph_pkg::*; #(
    parameter int W = 8
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         ce_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    typedef struct packed {
        logic [1:0][W-1:0] mem;
        logic [1:0]        cnt;
    } sph_buf_st_s;

    sph_buf_st_s st_reg;
    sph_buf_st_s st_next;
    logic        push;
    logic        pop;
    logic        idx;

    assign in_ready_o  = (st_reg.cnt != 2'h2);
    assign out_valid_o = (st_reg.cnt != 2'h0);
    assign out_data_o  = st_reg.mem[0];

    always_comb begin
        st_next = st_reg;
        push    = ce_i && in_valid_i && in_ready_o;
        pop     = ce_i && out_valid_o && out_ready_i;
        idx     = (st_reg.cnt == 2'h1) && !pop;
        if (pop) begin
            st_next.mem[0] = st_reg.mem[1];
        end
        if (push) begin
            st_next.mem[idx] = in_data_i;
        end
        st_next.cnt = st_reg.cnt + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg <= '0;
        end else if (ce_i) begin
            st_reg <= st_next;
        end
    end
endmodule : sph_buf2
`default_nettype wire

// file: rtl/sph_hs_chan.sv
// strobe/ack edge handshake, full flag and irq of one group
`default_nettype none
module sph_hs_chan import sph_pkg::*; (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic ce_i,
    input  wire logic in_en_i,
    input  wire logic out_en_i,
    input  wire logic stb_n_i,
    input  wire logic ack_n_i,
    input  wire logic rd_n_i,
    input  wire logic wr_n_i,
    input  wire logic in_full_i,
    input  wire logic in_room_i,
    input  wire logic in_gate_i,
    input  wire logic out_gate_i,
    output logic      obf_n_o,
    output logic      irq_o,
    output logic      push_o,
    output logic      pop_o
);
    sph_chan_s st_reg;
    sph_chan_s st_next;
    logic      stb_fall, stb_rise, ack_fall, ack_rise;
    logic      rd_fall, rd_rise, wr_fall, wr_rise;

    always_comb begin
        stb_fall = in_en_i && st_reg.stb_p && !stb_n_i;
        stb_rise = in_en_i && !st_reg.stb_p && stb_n_i;
        rd_fall  = in_en_i && st_reg.rd_p && !rd_n_i;
        rd_rise  = in_en_i && !st_reg.rd_p && rd_n_i;
        ack_fall = out_en_i && st_reg.ack_p && !ack_n_i;
        ack_rise = out_en_i && !st_reg.ack_p && ack_n_i;
        wr_fall  = out_en_i && st_reg.wr_p && !wr_n_i;
        wr_rise  = out_en_i && !st_reg.wr_p && wr_n_i;
        st_next       = st_reg;
        st_next.stb_p = stb_n_i;
        st_next.ack_p = ack_n_i;
        st_next.rd_p  = rd_n_i;
        st_next.wr_p  = wr_n_i;
        if (ack_fall) begin
            st_next.obf_n = 1'b1;
        end
        if (wr_rise) begin
            st_next.obf_n = 1'b0;
        end
        if (rd_fall) begin
            st_next.irq_in = 1'b0;
        end
        if (stb_rise && in_full_i && in_gate_i) begin
            st_next.irq_in = 1'b1;
        end
        if (wr_fall) begin
            st_next.irq_out = 1'b0;
        end
        if (ack_rise && st_reg.obf_n && out_gate_i) begin
            st_next.irq_out = 1'b1;
        end
        if (!in_en_i) begin
            st_next.irq_in = RST_FLAG;
        end
        if (!out_en_i) begin
            st_next.obf_n   = RST_OBF_N;
            st_next.irq_out = RST_FLAG;
        end
    end

    assign push_o  = stb_fall && in_room_i;
    assign pop_o   = rd_rise && in_full_i;
    assign obf_n_o = st_reg.obf_n;
    assign irq_o   = (st_reg.irq_in && in_gate_i)
                  || (st_reg.irq_out && out_gate_i);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg <= CHAN_RST;
        end else if (ce_i) begin
            st_reg <= st_next;
        end
    end

    sequence S_WR_RISE;
        ce_i && wr_rise;
    endsequence
    sequence S_ACK_FALL_ONLY;
        ce_i && ack_fall && !wr_rise;
    endsequence

    AST_OBF_SET: assert property (@(posedge clk_i) disable iff (rst_i)
        S_WR_RISE |=> !obf_n_o)
        else $error("output-full not set after write rise");
    AST_OBF_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
        S_ACK_FALL_ONLY |=> obf_n_o)
        else $error("output-full not cleared after ack fall");
    AST_IRQ_IN_SET: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && stb_rise && in_full_i && in_gate_i |=> irq_o)
        else $error("input irq missing after strobe rise");
    AST_IRQ_IN_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && rd_fall && !stb_rise && !out_en_i |=> !irq_o)
        else $error("input irq not dropped on read fall");
    AST_IRQ_OUT_SET: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && ack_rise && obf_n_o && out_gate_i |=> irq_o)
        else $error("output irq missing after ack rise");
    AST_IRQ_GATED: assert property (@(posedge clk_i) disable iff (rst_i)
        !in_gate_i && !out_gate_i |-> !irq_o)
        else $error("irq active while both gates clear");
endmodule : sph_hs_chan
`default_nettype wire

// file: tb/sph_periph_model.sv
// peripheral model: load strobe and acknowledge on port a
`default_nettype none
module sph_periph_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] pin_i,
    output logic            stb_n_o,
    output logic            ack_n_o,
    output logic [7:0]      drv_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        stb_n_o = 1'b1;
        ack_n_o = 1'b1;
        drv_o   = 8'h00;
    end
    // word held across the strobe, then strobe released and the lines driven with its complement
    task automatic push(input logic [7:0] v);
        @(posedge clk_i) drv_o <= v;
        @(posedge clk_i) stb_n_o <= 1'b0;
        repeat (2) @(posedge clk_i);
        stb_n_o <= 1'b1;
        @(posedge clk_i) drv_o <= ~v;
        repeat (3) @(posedge clk_i);
        #1;
    endtask : push
    task automatic pull(output logic [7:0] v);
        @(posedge clk_i) ack_n_o <= 1'b0;
        repeat (3) @(posedge clk_i);
        #1 v = pin_i;
        @(posedge clk_i) ack_n_o <= 1'b1;
        repeat (3) @(posedge clk_i);
        #1;
    endtask : pull
endmodule : sph_periph_model
`default_nettype wire

// file: tb/sph_ppi_top_tb.sv
// self-checking bench of the strobed port handshake block
`default_nettype none
module sph_ppi_top_tb import sph_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk_i = 1'b0;
    logic       rst_i = 1'b1;
    sph_cfg_s   cfg;
    sph_host_s  host;
    sph_bsr_s   bsr;
    logic [7:0] hd, pa_o, pc_o, pc_oe, pa_drv, d;
    logic [2:0] pc_lo;
    logic       hoe, pa_oe, stb_n, ack_n;
    wire  [7:0] pa_pin = pa_oe ? pa_o : pa_drv;
    int         fail_count = 0;
    int         n_compared = 0;
    sph_ppi_top sph_ppi_top_inst (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cfg_i(cfg),
        .host_i(host), .bsr_i(bsr), .host_data_o(hd),
        .host_data_oe_o(hoe), .pa_i(pa_pin), .pa_o(pa_o),
        .pa_oe_o(pa_oe), .pb_i(8'h00), .pb_o(), .pb_oe_o(),
        .pc_i({1'b1, ack_n, 1'b1, stb_n, 1'b1, pc_lo}),
        .pc_o(pc_o), .pc_oe_o(pc_oe));
    sph_periph_model sph_periph_model_inst (
        .clk_i(clk_i), .pin_i(pa_pin), .stb_n_o(stb_n),
        .ack_n_o(ack_n), .drv_o(pa_drv));
    task automatic chk(input string w, input logic [7:0] e,
                       input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s exp %h got %h", w, e, g);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : step
    task automatic hwr(input logic [1:0] a, input logic [7:0] v);
        @(posedge clk_i) host <= '{1'b1, 1'b0, a, v};
        repeat (2) @(posedge clk_i);
        host.wr_n <= 1'b1;
        step(3);
    endtask : hwr
    task automatic hrd(input logic [1:0] a);
        @(posedge clk_i) host <= '{1'b0, 1'b1, a, 8'h00};
        step(2);
        d = hd;
        chk("rd_oe", 8'h01, {7'h00, hoe});
        @(posedge clk_i) host.rd_n <= 1'b1;
        step(3);
    endtask : hrd
    task automatic bset(input logic [2:0] b, input logic v);
        @(posedge clk_i) bsr <= '{1'b1, b, v};
        @(posedge clk_i) bsr.we <= 1'b0;
        step(2);
    endtask : bset
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    initial begin
        repeat (5000) @(posedge clk_i);
        fail_count++;
        close_out();
    end
    initial begin
        cfg = '{SPH_M2, SPH_M0, 1'b0, 1'b0, 1'b0, 1'b0};
        host = '{1'b1, 1'b1, 2'h3, 8'h00};
        bsr = '0;
        pc_lo = 3'h7;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        step(2);
        chk("flags", 8'h80, pc_o & 8'hA8);
        chk("pc_oe", 8'hAF, pc_oe);
        bset(3'h6, 1'b1);
        bset(3'h4, 1'b1);
        hwr(ADDR_PA, 8'h5A);
        chk("obf_n", 8'h00, {7'h00, pc_o[7]});
        chk("pa_oe", 8'h00, {7'h00, pa_oe});
        sph_periph_model_inst.pull(d);
        chk("pa_pin", 8'h5A, d);
        chk("pa_oe", 8'h00, {7'h00, pa_oe});
        chk("obf_n", 8'h01, {7'h00, pc_o[7]});
        chk("irq", 8'h01, {7'h00, pc_o[3]});
        hwr(ADDR_PA, 8'hA5);
        chk("irq", 8'h00, {7'h00, pc_o[3]});
        sph_periph_model_inst.pull(d);
        chk("pa_pin", 8'hA5, d);
        bset(3'h6, 1'b0);
        chk("irq", 8'h00, {7'h00, pc_o[3]});
        sph_periph_model_inst.push(8'hC3);
        chk("ibf", 8'h01, {7'h00, pc_o[5]});
        chk("irq", 8'h01, {7'h00, pc_o[3]});
        chk("host_oe", 8'h00, {7'h00, hoe});
        sph_periph_model_inst.push(8'h3C);
        hrd(ADDR_PA);
        chk("rd", 8'hC3, d);
        chk("ibf", 8'h01, {7'h00, pc_o[5]});
        chk("irq", 8'h00, {7'h00, pc_o[3]});
        hrd(ADDR_PA);
        chk("rd", 8'h3C, d);
        chk("ibf", 8'h00, {7'h00, pc_o[5]});
        bset(3'h4, 1'b0);
        sph_periph_model_inst.push(8'h11);
        chk("irq", 8'h00, {7'h00, pc_o[3]});
        hrd(ADDR_PA);
        chk("rd", 8'h11, d);
        hwr(ADDR_PC, 8'hFF);
        chk("pc_lo", 8'h07, {5'h00, pc_o[2:0]});
        bset(3'h1, 1'b0);
        chk("pc_lo", 8'h05, {5'h00, pc_o[2:0]});
        @(posedge clk_i) cfg.pc_lo_in <= 1'b1;
        pc_lo <= 3'h2;
        hrd(ADDR_PC);
        chk("pc_in", 8'h02, {5'h00, d[2:0]});
        @(posedge clk_i) cfg <= '{SPH_M1, SPH_M1, 1'b0, 1'b1, 1'b0, 1'b1};
        step(2);
        chk("pc_oe", 8'hBB, pc_oe);
        hwr(ADDR_PC, 8'hFF);
        chk("pc_hi", 8'h00, {6'h00, pc_o[5:4]});
        bset(3'h5, 1'b1);
        chk("pc_hi", 8'h02, {6'h00, pc_o[5:4]});
        close_out();
    end
endmodule : sph_ppi_top_tb
`default_nettype wire
